// ### rtl/ssf_pkg.sv
// Constants and types of the synchronous serial master
// Summary of operation
// [R01] Frame-sync mode idle: clock and frame sync low, transmit line released.
// [R02] Frame-sync mode: with a word waiting, pulse frame sync one period and load it.
// [R03] Frame-sync mode: MSB goes out on the rising edge after the pulse.
// [R04] Frame-sync mode: incoming bits are sampled on falling clock edges.
// [R05] Received word goes to the receive side after its last bit is sampled.
// [R06] SPI clock idles at the programmed idle level between transfers.
// [R07] Phase zero captures on the first clock transition, phase one on the second.
// [R08] SPI idle: slave select high, MOSI pad released.
// [R09] Enabled with a word waiting: drive select low and enable MOSI.
// [R10] Idle low, phase zero: data half period after select, rising edge after.
// [R11] Idle low, phase one: first rising edge and data half period after select.
// [R12] Idle high, phase zero: data half period after select, falling edge after.
// [R13] Idle high, phase one: first falling edge and data half period after select.
// [R14] Select returns high one clock period after the final bit is captured.
// [R15] Phase zero back-to-back: select pulses high between words.
// [R16] Phase one back-to-back: select stays low; run ends like a single word.
// [R17] Slave with phase zero reloads its shifter only when select falls.
// [R18] Slave with phase zero presents its first bit when select falls.
// [R19] Mode, idle level, phase and width are latched for the transfer.
package ssf_pkg;
    localparam int CORE_PERIOD_NS = 20;
    localparam int SCK_PERIOD_NS = 160;
    localparam int HALF_CYCLES = SCK_PERIOD_NS / (2 * CORE_PERIOD_NS);
    localparam logic [2:0] HALF_CNT_MAX = 3'(HALF_CYCLES - 1);
    localparam int CAP_LAG = 4;
    localparam int WORD_W = 16;
    localparam logic [3:0] WIDTH_MAX_M1 = 4'hf;
    localparam logic [15:0] WORD_ONES = 16'hffff;
    localparam logic [15:0] WORD_RST = 16'h0000;

    typedef struct packed {
        logic frame_sync_mode;
        logic clock_idle_level;
        logic clock_sample_phase;
        logic [3:0] word_bits_m1;
    } ssf_cfg_t;

    typedef struct packed {
        logic sclk;
        logic ssel_b;
        logic frame_sync_pulse;
        logic mosi;
        logic mosi_oe;
    } ssf_pins_t;

    localparam ssf_cfg_t CFG_RST = 7'h00;
    localparam ssf_pins_t PINS_RST = 5'h08;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LEAD = 2'b01,
        ST_BITS = 2'b10,
        ST_TAIL = 2'b11
    } ssf_state_t;
endpackage

// ### rtl/ssf_master.sv
// Synchronous serial master: frame-sync and four SPI clock variants
`timescale 1ns/100ps
module ssf_master
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_enable,
    input wire ssf_pkg::ssf_cfg_t i_cfg,
    input wire logic i_tx_valid,
    input wire logic [15:0] i_tx_data,
    output logic o_tx_ready,
    output logic o_rx_valid,
    output logic [15:0] o_rx_data,
    output logic o_busy,
    output logic o_sclk,
    output logic o_ssel_b,
    output logic o_frame_sync_pulse,
    output logic o_mosi,
    output logic o_mosi_oe,
    input wire logic i_miso
);
    logic [2:0] div_r;
    logic tick;
    ssf_pkg::ssf_state_t state_r;
    logic half_r;
    logic [3:0] bit_r;
    ssf_pkg::ssf_cfg_t cfg_r;
    logic [15:0] tx_sh_r;
    logic [15:0] rx_sh_r;
    logic [ssf_pkg::CAP_LAG-1:0] cap_pipe_r;
    logic [ssf_pkg::CAP_LAG-1:0] last_pipe_r;
    logic miso_s1_r;
    logic miso_s2_r;
    logic miso_s3_r;
    logic miso_r;
    logic rx_valid_r;
    logic [15:0] rx_data_r;
    ssf_pkg::ssf_pins_t pins_r;
    ssf_pkg::ssf_pins_t pins_nxt;
    logic fs_m;
    logic clock_sample_phase_eff;
    logic idle_lvl;
    logic idle_in;
    logic last_bit;
    logic end_bit;
    logic cap_now;
    logic start_ok;
    logic chain;
    logic [15:0] rx_mask;
    logic [15:0] rx_word;

    // Half-period enable from a free-running divider
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            div_r <= 3'h0;
        else if (tick)
            div_r <= 3'h0;
        else
            div_r <= div_r + 3'h1;
    end
    assign tick = (div_r == ssf_pkg::HALF_CNT_MAX);

    assign fs_m = cfg_r.frame_sync_mode;
    assign clock_sample_phase_eff = fs_m | cfg_r.clock_sample_phase;
    assign idle_lvl = ~fs_m & cfg_r.clock_idle_level;
    assign idle_in = ~i_cfg.frame_sync_mode & i_cfg.clock_idle_level;
    assign last_bit = (bit_r == cfg_r.word_bits_m1);
    assign end_bit = tick && (state_r == ssf_pkg::ST_BITS) && half_r;
    assign cap_now = tick && (state_r == ssf_pkg::ST_BITS) && !half_r;
    assign start_ok = tick && (state_r == ssf_pkg::ST_IDLE) && i_enable && i_tx_valid; // R09
    // Phase one and frame-sync runs take the next word without releasing select
    assign chain = end_bit && last_bit && i_enable && i_tx_valid && clock_sample_phase_eff; // R16
    assign o_tx_ready = start_ok || chain; // R02
    assign o_busy = (state_r != ssf_pkg::ST_IDLE);

    // Sequencer: each bit is a drive half followed by a capture half
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_r <= ssf_pkg::ST_IDLE;
            half_r <= 1'b0;
            bit_r <= 4'h0;
        end
        else if (tick)
        begin
            case (state_r)
                ssf_pkg::ST_IDLE:
                begin
                    half_r <= 1'b0;
                    if (start_ok)
                        state_r <= ssf_pkg::ST_LEAD;
                end
                ssf_pkg::ST_LEAD:
                begin
                    // Frame sync needs a whole period, select lead only half
                    if (!fs_m || half_r) // R02
                    begin
                        state_r <= ssf_pkg::ST_BITS;
                        half_r <= 1'b0;
                        bit_r <= 4'h0;
                    end
                    else
                        half_r <= 1'b1;
                end
                ssf_pkg::ST_BITS:
                begin
                    if (!half_r)
                        half_r <= 1'b1;
                    else
                    begin
                        half_r <= 1'b0;
                        if (!last_bit)
                            bit_r <= bit_r + 4'h1;
                        else if (chain)
                        begin
                            bit_r <= 4'h0; // R16
                            if (fs_m)
                                state_r <= ssf_pkg::ST_LEAD;
                        end
                        else if (fs_m)
                            state_r <= ssf_pkg::ST_IDLE;
                        else
                            state_r <= ssf_pkg::ST_TAIL; // R14
                    end
                end
                ssf_pkg::ST_TAIL:
                    state_r <= ssf_pkg::ST_IDLE; // R15
                default:
                    state_r <= ssf_pkg::ST_IDLE;
            endcase
        end
    end

    // Settings change only between transfers, never inside a run
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            cfg_r <= ssf_pkg::CFG_RST;
        else if (start_ok)
            cfg_r <= i_cfg; // R19
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            tx_sh_r <= ssf_pkg::WORD_RST;
        else if (o_tx_ready && i_tx_valid)
            tx_sh_r <= i_tx_data; // R02
        else if (end_bit && !last_bit)
            tx_sh_r <= {tx_sh_r[14:0], 1'b0}; // R03
    end

    // Three-stage sampler; a change counts once the last two agree
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            miso_s1_r <= 1'b0;
            miso_s2_r <= 1'b0;
            miso_s3_r <= 1'b0;
            miso_r <= 1'b0;
        end
        else
        begin
            miso_s1_r <= i_miso;
            miso_s2_r <= miso_s1_r;
            miso_s3_r <= miso_s2_r;
            if (miso_s2_r == miso_s3_r)
                miso_r <= miso_s3_r;
        end
    end

    // Capture is delayed to cover the pin register and sampler latency
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cap_pipe_r <= '0;
            last_pipe_r <= '0;
        end
        else
        begin
            cap_pipe_r <= {cap_pipe_r[ssf_pkg::CAP_LAG-2:0], cap_now}; // R07
            last_pipe_r <= {last_pipe_r[ssf_pkg::CAP_LAG-2:0], last_bit};
        end
    end

    assign rx_mask = ssf_pkg::WORD_ONES >> (ssf_pkg::WIDTH_MAX_M1 - cfg_r.word_bits_m1);
    assign rx_word = {rx_sh_r[14:0], miso_r} & rx_mask;

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            rx_sh_r <= ssf_pkg::WORD_RST;
        else if (cap_pipe_r[ssf_pkg::CAP_LAG-1])
            rx_sh_r <= {rx_sh_r[14:0], miso_r}; // R04
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rx_valid_r <= 1'b0;
            rx_data_r <= ssf_pkg::WORD_RST;
        end
        else
        begin
            rx_valid_r <= cap_pipe_r[ssf_pkg::CAP_LAG-1] && last_pipe_r[ssf_pkg::CAP_LAG-1];
            if (cap_pipe_r[ssf_pkg::CAP_LAG-1] && last_pipe_r[ssf_pkg::CAP_LAG-1])
                rx_data_r <= rx_word; // R05
        end
    end
    assign o_rx_valid = rx_valid_r;
    assign o_rx_data = rx_data_r;

    // Pin levels from the sequencer, registered to keep the pads glitch free
    always_comb
    begin
        pins_nxt = ssf_pkg::PINS_RST;
        case (state_r)
            ssf_pkg::ST_IDLE:
                pins_nxt.sclk = idle_in; // R01 R06 R08
            ssf_pkg::ST_LEAD:
            begin
                pins_nxt.ssel_b = fs_m;
                pins_nxt.frame_sync_pulse = fs_m; // R02
                pins_nxt.mosi_oe = 1'b1; // R09
                pins_nxt.sclk = fs_m ? ~half_r : idle_lvl; // R10 R12
            end
            ssf_pkg::ST_BITS:
            begin
                pins_nxt.ssel_b = fs_m; // R16
                pins_nxt.mosi_oe = 1'b1;
                pins_nxt.mosi = tx_sh_r[cfg_r.word_bits_m1]; // R03
                pins_nxt.sclk = idle_lvl ^ (clock_sample_phase_eff ? ~half_r : half_r); // R07 R11 R13
            end
            ssf_pkg::ST_TAIL:
            begin
                pins_nxt.ssel_b = 1'b0;
                pins_nxt.mosi_oe = 1'b1;
                pins_nxt.mosi = tx_sh_r[cfg_r.word_bits_m1];
                pins_nxt.sclk = idle_lvl; // R14
            end
            default:
                pins_nxt = ssf_pkg::PINS_RST;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            pins_r <= ssf_pkg::PINS_RST;
        else
            pins_r <= pins_nxt;
    end
    assign o_sclk = pins_r.sclk;
    assign o_ssel_b = pins_r.ssel_b;
    assign o_frame_sync_pulse = pins_r.frame_sync_pulse;
    assign o_mosi = pins_r.mosi;
    assign o_mosi_oe = pins_r.mosi_oe;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    idle_pins_a: assert property ( // R01
        (state_r == ssf_pkg::ST_IDLE) && $past(state_r == ssf_pkg::ST_IDLE)
        |=> o_ssel_b && !o_mosi_oe && !o_frame_sync_pulse)
        else $error("Pins not idle");
    idle_clock_a: assert property ( // R06
        (state_r == ssf_pkg::ST_IDLE) |=> (o_sclk == $past(idle_in)))
        else $error("Clock not at idle level");
    fs_pulse_a: assert property ( // R02
        $rose(o_frame_sync_pulse) |-> o_frame_sync_pulse[*8] ##1 !o_frame_sync_pulse)
        else $error("Frame sync not one period");
    fs_msb_a: assert property ( // R03
        $fell(o_frame_sync_pulse) |-> $rose(o_sclk))
        else $error("First bit not on rising edge");
    capture_edge_a: assert property ( // R04
        cap_now |-> ##2 $changed(o_sclk) && (o_sclk == (clock_sample_phase_eff ? idle_lvl : ~idle_lvl)))
        else $error("Capture on wrong edge");
    rx_push_a: assert property ( // R05
        end_bit && last_bit |-> ##[1:6] o_rx_valid)
        else $error("Received word not pushed");
    select_start_a: assert property ( // R09
        $fell(o_ssel_b) |-> o_mosi_oe && !o_frame_sync_pulse)
        else $error("MOSI not enabled at select");
    lead_ph0_a: assert property ( // R10
        $fell(o_ssel_b) && !cfg_r.clock_sample_phase
        |-> $stable(o_sclk)[*8] ##1 $changed(o_sclk))
        else $error("Phase zero lead wrong");
    lead_ph1_a: assert property ( // R11
        $fell(o_ssel_b) && cfg_r.clock_sample_phase
        |-> $stable(o_sclk)[*4] ##1 $changed(o_sclk))
        else $error("Phase one lead wrong");
    tail_len_a: assert property ( // R14
        $rose(state_r == ssf_pkg::ST_TAIL)
        |-> (state_r == ssf_pkg::ST_TAIL)[*4] ##1 (state_r == ssf_pkg::ST_IDLE))
        else $error("Select tail wrong length");
    select_gap_a: assert property ( // R15
        $rose(o_ssel_b) |-> o_ssel_b[*4])
        else $error("Select gap too short");
    select_hold_a: assert property ( // R16
        chain && !fs_m |=> (state_r == ssf_pkg::ST_BITS) ##1 !o_ssel_b)
        else $error("Select released in phase one run");
    cfg_hold_a: assert property ( // R19
        (state_r != ssf_pkg::ST_IDLE) && $past(state_r != ssf_pkg::ST_IDLE) |-> $stable(cfg_r))
        else $error("Settings changed in transfer");
endmodule

// ### sim/ssf_slave_model.sv
// Behavioural model of the off-chip serial slave, echoing the last word it received
`timescale 1ns/100ps
module ssf_slave_model
(
    input wire logic i_sclk,
    input wire logic i_ssel_b,
    input wire logic i_fs,
    input wire logic i_mosi,
    input wire ssf_pkg::ssf_cfg_t i_cfg,
    output logic o_miso,
    output logic [15:0] o_word,
    output int o_count
);
    logic [15:0] echo = 16'ha5c3;
    logic [15:0] tx = 16'h0000;
    logic [15:0] rx = 16'h0000;
    int k = 0;
    int c = 0;
    int n = 16;
    logic armed = 1'b0;
    initial
    begin
        o_miso = 1'b0;
        o_word = 16'h0000;
        o_count = 0;
    end
    task automatic take();
        rx = {rx[14:0], i_mosi};
        c++;
        if (c % n == 0)
        begin
            o_word = rx & (16'hffff >> (16 - n));
            echo = o_word;
            o_count++;
        end
    endtask
    task automatic start();
        n = int'(i_cfg.word_bits_m1) + 1;
        tx = echo;
        k = 0;
        c = 0;
    endtask
    always @(negedge i_ssel_b)
        if (!i_cfg.frame_sync_mode)
        begin
            start();
            if (!i_cfg.clock_sample_phase)
                o_miso = tx[n - 1];
        end
    // No pull on the line, so a released slave shows the inverse of its last bit
    always @(posedge i_ssel_b)
        o_miso = ~o_miso;
    always @(i_sclk)
        if (!i_cfg.frame_sync_mode && !i_ssel_b)
        begin
            if ((i_sclk != i_cfg.clock_idle_level) ^ i_cfg.clock_sample_phase)
                take();
            else if (i_cfg.clock_sample_phase)
            begin
                if (k % n == 0)
                    tx = echo;
                o_miso = tx[n - 1 - k % n];
                k++;
            end
            else
            begin
                k++;
                o_miso = tx[n - 1 - k % n];
            end
        end
    // Frame sync moves on the same core edge as the clock, so let it settle first
    always @(posedge i_sclk)
        if (i_cfg.frame_sync_mode)
        begin
            #1;
            if (i_fs)
            begin
                start();
                armed = 1'b1;
            end
            else if (armed && k < n)
            begin
                o_miso = tx[n - 1 - k];
                k++;
            end
        end
    always @(negedge i_sclk)
        if (i_cfg.frame_sync_mode && armed && k > 0)
        begin
            take();
            if (c == n)
            begin
                armed = 1'b0;
                o_miso = ~o_miso;
            end
        end
endmodule

// ### sim/test_ssf_master.sv
// Self-checking bench of the synchronous serial master
`timescale 1ns/100ps
module test_ssf_master;
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_enable = 1'b0;
    ssf_pkg::ssf_cfg_t i_cfg = ssf_pkg::CFG_RST;
    logic i_tx_valid = 1'b0;
    logic [15:0] i_tx_data = 16'h0000;
    logic o_tx_ready, o_rx_valid, o_busy, o_sclk, o_ssel_b, o_fs, o_mosi, o_mosi_oe, i_miso;
    logic [15:0] o_rx_data, sl_word, m;
    logic [15:0] echo = 16'ha5c3;
    logic [15:0] q_rx[$];
    logic [15:0] q_sl[$];
    int sl_count, rises, w;
    int fails = 0;
    int compares = 0;
    int seed = 32'h3ea0;
    int cyc = 0;
    int fs_len = 0;
    ssf_master i_ssf_master(.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_enable(i_enable),
        .i_cfg(i_cfg), .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data), .o_tx_ready(o_tx_ready),
        .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data), .o_busy(o_busy), .o_sclk(o_sclk),
        .o_ssel_b(o_ssel_b), .o_frame_sync_pulse(o_fs), .o_mosi(o_mosi),
        .o_mosi_oe(o_mosi_oe), .i_miso(i_miso));
    ssf_slave_model i_ssf_slave_model(.i_sclk(o_sclk), .i_ssel_b(o_ssel_b), .i_fs(o_fs),
        .i_mosi(o_mosi), .i_cfg(i_cfg), .o_miso(i_miso), .o_word(sl_word), .o_count(sl_count));
    always #10 i_core_clk = ~i_core_clk;
    task automatic end_sim();
        if (fails == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    // Ceiling well above the longest run of fifteen three-word transfers
    always @(negedge i_core_clk)
    begin
        cyc++;
        if (o_rx_valid === 1'b1)
            chk(q_rx.size() > 0 && o_rx_data === q_rx.pop_front(), "rx word");
        if (o_fs === 1'b1)
            fs_len++;
        else if (fs_len > 0)
        begin
            chk(fs_len == 2 * ssf_pkg::HALF_CYCLES, "sync width");
            fs_len = 0;
        end
        // Checked last so that nothing in this process runs after the finish
        if (cyc == 60000)
        begin
            fails++;
            end_sim();
        end
    end
    // Word and count reach the bench through separate port copies, so let both settle
    always @(sl_count)
    begin
        #1;
        if (sl_count > 0)
            chk(q_sl.size() > 0 && sl_word === q_sl.pop_front(), "slave word");
    end
    always @(posedge o_ssel_b)
        rises++;
    task automatic put(input logic [15:0] d);
        m = ssf_pkg::WORD_ONES >> (4'hf - i_cfg.word_bits_m1);
        i_tx_data = d & m;
        i_tx_valid = 1'b1;
        q_sl.push_back(d & m);
        q_rx.push_back(echo & m);
        echo = d & m;
        #1;
        while (o_tx_ready !== 1'b1)
        begin
            @(negedge i_core_clk);
            #1;
        end
        @(negedge i_core_clk);
    endtask
    task automatic run(input logic [6:0] c, input int words);
        i_cfg = c;
        @(negedge i_core_clk);
        rises = 0;
        repeat (words) put(16'($random(seed)));
        i_tx_valid = 1'b0;
        chk(o_busy === 1'b1, "not busy in transfer");
        while (o_busy !== 1'b0)
            @(negedge i_core_clk);
        repeat (12) @(negedge i_core_clk);
        chk(q_rx.size() == 0 && q_sl.size() == 0, "words lost");
        chk(o_ssel_b === 1'b1 && o_mosi_oe === 1'b0 && o_fs === 1'b0, "idle pins");
        chk(o_sclk === (c[5] && !c[6]), "idle clock");
        chk(rises == (c[6] ? 0 : c[4] ? 1 : words), "select pulses");
    endtask
    initial
    begin
        repeat (12) @(negedge i_core_clk);
        i_rst_b = 1'b1;
        i_tx_valid = 1'b1;
        // Disabled port must leave a waiting word alone
        repeat (40)
        begin
            @(negedge i_core_clk);
            chk(o_tx_ready === 1'b0 && o_ssel_b === 1'b1, "start while off");
        end
        i_tx_valid = 1'b0;
        i_enable = 1'b1;
        for (int i = 0; i < 15; i++)
        begin
            w = i < 5 ? 3 : i < 10 ? 15 : 3 + ($unsigned($random(seed)) % 13);
            run({i % 5 == 4, 2'(i % 5), 4'(w)}, 3);
        end
        end_sim();
    end
endmodule
